// *** inc/sol_pkg.sv ***
// package for the switch output limit logic: register map, encodings, timing
package sol_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DELAY_STEP_MS = 100;
  localparam int unsigned STEP_CYCLES_DEF = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam logic [9:0] DELAY_MAX_STEPS = 10'h3E8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ON_THR = 8'h04;
  localparam logic [7:0] REG_OFF_THR = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control and delay field positions
  localparam int unsigned CTRL_FUNC_LSB = 0;
  localparam int unsigned CTRL_DIAG_LSB = 4;
  localparam int unsigned CTRL_FAIL_LSB = 6;
  localparam int unsigned CTRL_INV_BIT = 8;
  localparam int unsigned CTRL_ASSIGN_BIT = 9;
  localparam int unsigned CTRL_SRC_LSB = 12;
  localparam int unsigned DELAY_OFF_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] THR_RESET = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    SOL_FN_OFF = 3'h0,
    SOL_FN_ON = 3'h1,
    SOL_FN_DIAG = 3'h2,
    SOL_FN_LIMIT = 3'h3,
    SOL_FN_DOUT = 3'h4
  } sol_func_e;

  typedef enum logic [1:0] {
    SOL_DG_ALARM = 2'h0,
    SOL_DG_BOTH = 2'h1,
    SOL_DG_WARN = 2'h2
  } sol_diag_e;

  typedef enum logic [1:0] {
    SOL_FM_ACTUAL = 2'h0,
    SOL_FM_OPEN = 2'h1,
    SOL_FM_CLOSED = 2'h2
  } sol_fail_e;

  typedef struct packed {
    logic alarm;
    logic warning;
  } sol_diag_s;
endpackage : sol_pkg

// *** core/sol_delay.sv ***
// switch-on/switch-off delay timer in tenth-second steps
`timescale 1ns/1ps
`default_nettype none
module sol_delay
  import sol_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cond_i,
  input wire logic [9:0] steps_i,
  output logic fire_o
);
  initial begin
    if (STEP_CYCLES < 1) $error("step must be at least one cycle");
  end

  logic [31:0] tick_q;
  logic [9:0] step_q;
  logic done;

  assign done = (step_q >= steps_i);
  assign fire_o = cond_i & done;

  // restart whenever the condition drops, so a blip shorter than steps_i never switches
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !cond_i) begin
      tick_q <= 32'h0000_0000;
      step_q <= 10'h000;
    end else if (!done) begin
      if (tick_q == STEP_CYCLES - 1) begin
        tick_q <= 32'h0000_0000;
        step_q <= step_q + 10'h001;
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end
endmodule : sol_delay
`default_nettype wire

// *** core/sol_switch.sv ***
// switch output logic with wishbone register file
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sol_switch
  import sol_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF,
  parameter int unsigned NUM_SRC = 6
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] meas_i,
  input wire sol_diag_s diag_i,
  input wire logic [NUM_SRC-1:0] dsrc_i,
  output logic switch_closed_o
);
  initial begin
    if (NUM_SRC < 1 || NUM_SRC > 15) $error("NUM_SRC must be 1 to 15");
  end

  logic [31:0] ctrl_q;
  logic [31:0] on_thr_q;
  logic [31:0] off_thr_q;
  logic [31:0] delay_q;
  logic limit_q;
  logic out_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;

  sol_func_e func;
  sol_diag_e diag_sel;
  sol_fail_e fail_sel;
  logic [3:0] src_sel;
  logic invert;
  logic assigned;
  logic req;

  assign func = sol_func_e'(ctrl_q[CTRL_FUNC_LSB +: 3]);
  assign diag_sel = sol_diag_e'(ctrl_q[CTRL_DIAG_LSB +: 2]);
  assign fail_sel = sol_fail_e'(ctrl_q[CTRL_FAIL_LSB +: 2]);
  assign invert = ctrl_q[CTRL_INV_BIT];
  assign assigned = ctrl_q[CTRL_ASSIGN_BIT];
  assign src_sel = ctrl_q[CTRL_SRC_LSB +: 4];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_q;

  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= req;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET;
      on_thr_q <= THR_RESET;
      off_thr_q <= THR_RESET;
      delay_q <= DELAY_RESET;
    end else if (req && wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_F3F7;
        REG_ON_THR: on_thr_q <= merge(on_thr_q, wb_dat_i, wb_sel_i);
        REG_OFF_THR: off_thr_q <= merge(off_thr_q, wb_dat_i, wb_sel_i);
        REG_DELAY: delay_q <= merge(delay_q, wb_dat_i, wb_sel_i) & 32'h03FF_03FF;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_q <= 32'h0000_0000;
    end else if (req) begin
      unique case (wb_adr_i)
        REG_CTRL: wb_dat_q <= ctrl_q;
        REG_ON_THR: wb_dat_q <= on_thr_q;
        REG_OFF_THR: wb_dat_q <= off_thr_q;
        REG_DELAY: wb_dat_q <= delay_q;
        REG_STATUS: wb_dat_q <= {30'h0000_0000, limit_q, out_q};
        default: wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ieee single compare, total order; both zeros equal, nan not handled
  function automatic logic flt_gt(input logic [31:0] a, input logic [31:0] b);
    logic r;
    r = 1'b0;
    if ((a[30:0] == 31'h0) && (b[30:0] == 31'h0)) begin
      r = 1'b0;
    end else if (a[31] != b[31]) begin
      r = b[31];
    end else if (!a[31]) begin
      r = (a[30:0] > b[30:0]);
    end else begin
      r = (a[30:0] < b[30:0]);
    end
    return r;
  endfunction : flt_gt

  logic dir_up;
  logic close_cond;
  logic open_cond;
  logic close_fire;
  logic open_fire;
  logic [9:0] on_steps;
  logic [9:0] off_steps;

  assign dir_up = flt_gt(on_thr_q, off_thr_q);
  always_comb begin
    if (dir_up) begin
      close_cond = flt_gt(meas_i, on_thr_q);
      open_cond = flt_gt(off_thr_q, meas_i);
    end else begin
      close_cond = flt_gt(on_thr_q, meas_i);
      open_cond = flt_gt(meas_i, off_thr_q);
    end
  end

  // steps above the documented range are clamped to 100 s
  assign on_steps = (delay_q[9:0] > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : delay_q[9:0];
  assign off_steps = (delay_q[DELAY_OFF_LSB +: 10] > DELAY_MAX_STEPS) ?
                     DELAY_MAX_STEPS : delay_q[DELAY_OFF_LSB +: 10];

  logic arm_close;
  logic arm_open;
  assign arm_close = (func == SOL_FN_LIMIT) & assigned & close_cond & ~limit_q;
  assign arm_open = (func == SOL_FN_LIMIT) & assigned & open_cond & limit_q;

  sol_delay #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_on_delay (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(arm_close),
    .steps_i(on_steps),
    .fire_o(close_fire)
  );

  sol_delay #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_off_delay (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(arm_open),
    .steps_i(off_steps),
    .fire_o(open_fire)
  );

  // limit state is held between thresholds; unassigned limit stays open
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || func != SOL_FN_LIMIT || !assigned) begin
      limit_q <= 1'b0;
    end else if (close_fire) begin
      limit_q <= 1'b1;
    end else if (open_fire) begin
      limit_q <= 1'b0;
    end
  end

  logic diag_hit;
  logic dsrc_val;
  logic base;
  logic final_st;

  always_comb begin
    unique case (diag_sel)
      SOL_DG_ALARM: diag_hit = diag_i.alarm;
      SOL_DG_BOTH: diag_hit = diag_i.alarm | diag_i.warning;
      SOL_DG_WARN: diag_hit = diag_i.warning;
      default: diag_hit = diag_i.alarm;
    endcase
  end

  // source 0 is off; 1..NUM_SRC pick a digital input
  always_comb begin
    dsrc_val = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (src_sel == 4'(i + 1)) begin
        dsrc_val = dsrc_i[i];
      end
    end
  end

  always_comb begin
    unique case (func)
      SOL_FN_OFF: base = 1'b0;
      SOL_FN_ON: base = 1'b1;
      SOL_FN_DIAG: base = ~diag_hit;
      SOL_FN_LIMIT: base = limit_q;
      SOL_FN_DOUT: base = dsrc_val;
      default: base = 1'b0;
    endcase
    final_st = base;
    if ((func == SOL_FN_LIMIT || func == SOL_FN_DOUT) && diag_i.alarm) begin
      unique case (fail_sel)
        SOL_FM_OPEN: final_st = 1'b0;
        SOL_FM_CLOSED: final_st = 1'b1;
        default: final_st = base;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= final_st;
    end
  end

  assign switch_closed_o = out_q ^ invert;

  sequence on_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  wb_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    on_req_s |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  off_mode_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_OFF && $stable(ctrl_q) |=> out_q == 1'b0) else $error("off mode closed");
  on_mode_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_ON && $stable(ctrl_q) |=> out_q == 1'b1) else $error("on mode open");
  diag_open_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_DIAG && diag_i.alarm && diag_sel != SOL_DG_WARN |=> !out_q) else $error("alarm left closed");
  diag_warn_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_DIAG && diag_i.warning && !diag_i.alarm && diag_sel == SOL_DG_ALARM |=> out_q)
    else $error("warning opened alarm-only output");
  dout_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_DOUT && !diag_i.alarm |=> out_q == $past(dsrc_val)) else $error("digital source not followed");
  fail_force_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_LIMIT && diag_i.alarm && fail_sel == SOL_FM_CLOSED |=> out_q) else $error("failure close ignored");
  limit_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_LIMIT && $stable(ctrl_q) && !close_fire && !open_fire |=> $stable(limit_q))
    else $error("limit changed without cause");
  close_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(limit_q) |-> $past(arm_close)) else $error("closed without condition");
  zero_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    arm_close && on_steps == 10'h000 |=> limit_q) else $error("zero delay not immediate");
  invert_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    func == SOL_FN_ON && $stable(ctrl_q) |=> switch_closed_o == !invert) else $error("inversion wrong");
endmodule : sol_switch
`default_nettype wire

// *** bench/sol_load.sv ***
// load model wired across the switch contact
`timescale 1ns/1ps
`default_nettype none
module sol_load (
  input wire logic sys_clk_i,
  input wire logic contact_i,
  output logic current_o
);
  // resistive load: current settles one cycle after the contact moves
  always_ff @(posedge sys_clk_i) begin
    current_o <= contact_i;
  end
endmodule : sol_load
`default_nettype wire

// *** bench/sol_switch_bench.sv ***
// bench for the switch output: bus driver, note queue, output monitor
`timescale 1ns/1ps
`default_nettype none
module sol_switch_bench;
  import sol_pkg::*;
  `define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
  typedef struct {string nm; logic [31:0] e;} sol_note_s;
  sol_note_s q[$];
  sol_note_s nt;
  logic sys_clk_i, rst_n_i, cyc, stb, we, ack, sw, sw_req, load_on;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, meas;
  sol_diag_s diag;
  logic [5:0] dsrc;
  int error_cnt, cmp_count;
  // short step keeps the delay runs to 8 and 12 cycles
  sol_switch #(.STEP_CYCLES(4), .NUM_SRC(6)) uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .meas_i(meas), .diag_i(diag), .dsrc_i(dsrc), .switch_closed_o(sw));
  sol_load load (.sys_clk_i(sys_clk_i), .contact_i(sw), .current_o(load_on));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge sys_clk_i) begin
    if ((ack === 1'b1 && we === 1'b0) || sw_req) begin
      nt = q.pop_front();
      `CHK(nt.nm, nt.e, sw_req ? {31'h0, sw} : rdat)
      if (sw_req) `CHK("load", nt.e[0], load_on)
    end
  end
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    q.push_back('{nm, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task automatic sw_chk(input logic e, input string nm);
    q.push_back('{nm, {31'h0, e}});
    sw_req <= 1'b1;
    @(posedge sys_clk_i);
    sw_req <= 1'b0;
    @(posedge sys_clk_i);
  endtask : sw_chk
  task automatic lim(input logic [31:0] v, input int k, input logic e, input string nm);
    @(posedge sys_clk_i);
    meas <= v;
    idle(k);
    sw_chk(e, nm);
  endtask : lim
  initial begin
    #500_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    logic ex;
    {rst_n_i, cyc, stb, we, sw_req, adr, wdat, meas, dsrc} = '0;
    diag = '0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'hb93e_7bcb));
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    sw_chk(1'b0, "sw_rst");
    rd(REG_CTRL, CTRL_RESET, "ctrl_rst");
    rd(REG_DELAY, DELAY_RESET, "dly_rst");
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0000_0000, "unmapped");
    wr(REG_CTRL, 32'h0000_0001);
    idle(2);
    sw_chk(1'b1, "fn_on");
    wr(REG_CTRL, 32'h0000_0101);
    idle(2);
    sw_chk(1'b0, "fn_on_inv");
    rd(REG_STATUS, 32'h0000_0001, "status");
    wr(REG_CTRL, 32'h0000_0000);
    idle(2);
    sw_chk(1'b0, "fn_off");
    for (int c = 0; c < 3; c++) begin
      wr(REG_CTRL, 32'h0000_0002 | (c << 4));
      for (int d = 0; d < 4; d++) begin
        @(posedge sys_clk_i);
        diag <= sol_diag_s'(d[1:0]);
        idle(2);
        ex = !((c == 0 && d[1]) || (c == 1 && d != 0) || (c == 2 && d[0]));
        sw_chk(ex, "diag");
      end
    end
    // failure policy only bites while the alarm is up, so it is randomised
    for (int f = 0; f < 3; f++) begin
      for (int s = 1; s <= 6; s++) begin
        wr(REG_CTRL, 32'h0000_0004 | (f << 6) | (s << 12));
        @(posedge sys_clk_i);
        dsrc <= 6'($urandom);
        diag <= sol_diag_s'(2'($urandom));
        idle(2);
        ex = (diag.alarm && f != 0) ? (f == 2) : dsrc[s - 1];
        sw_chk(ex, "dout");
      end
    end
    @(posedge sys_clk_i);
    diag <= '0;
    wr(REG_ON_THR, 32'h4040_0000);
    wr(REG_OFF_THR, 32'h3f80_0000);
    wr(REG_CTRL, 32'h0000_0203);
    lim(32'h40a0_0000, 4, 1'b1, "lim_up");
    lim(32'h4000_0000, 4, 1'b1, "lim_hold");
    lim(32'h0000_0000, 4, 1'b0, "lim_dn");
    wr(REG_ON_THR, 32'hbf80_0000);
    lim(32'h0000_0000, 4, 1'b0, "lim_band");
    lim(32'hc000_0000, 4, 1'b1, "lim_low");
    lim(32'h4000_0000, 4, 1'b0, "lim_high");
    wr(REG_ON_THR, 32'h4040_0000);
    wr(REG_DELAY, 32'h0003_0002);
    lim(32'h40a0_0000, 2, 1'b0, "dly_start");
    lim(32'h4000_0000, 16, 1'b0, "dly_abort");
    lim(32'h40a0_0000, 5, 1'b0, "on_early");
    lim(32'h40a0_0000, 5, 1'b1, "on_late");
    lim(32'h0000_0000, 8, 1'b1, "off_early");
    lim(32'h0000_0000, 8, 1'b0, "off_late");
    wr(REG_CTRL, 32'h0000_0283);
    @(posedge sys_clk_i);
    diag <= sol_diag_s'(2'h2);
    idle(2);
    sw_chk(1'b1, "lim_fail");
    @(posedge sys_clk_i);
    diag <= '0;
    idle(2);
    sw_chk(1'b0, "lim_fail_end");
    stop_test();
  end
endmodule : sol_switch_bench
`default_nettype wire
